// [common/gtc_consts.vh]
// Contract
// (R1) Timers 0 and 1 each offer four operating modes chosen by a two-bit mode field of their configuration nibble.
// (R2) Mode 0 is an 8-bit counter behind a divide-by-32 prescaler, advancing once per 32 input counts.
// (R3) Mode 2 is an 8-bit counter that reloads from a second 8-bit register on each overflow.
// (R4) Mode 3 splits timer 0 into an 8-bit timer/counter and a separate 8-bit timer while timer 1 halts; the code halts timer 1 only in its own mode 3.
// (R5) With the counter select bit at 0 the count advances once per machine cycle, the clock divided by 12.
// (R6) With the counter select bit at 1 the count advances on each falling edge seen on the unit's count pin.
// (R7) Falling-edge detection takes two machine cycles, so a count pin may toggle at most at clock/24.
// (R8) Timers 0 and 1 can each use their gate pin as a count gate for pulse-width measurement.
// (R9) Timer 2 is a 16-bit up/down counter whose select bit picks machine cycles or external events.
// (R10) Timer 2 has auto-reload, capture and baud-generator modes, and stops while its run bit is 0.
// (R11) In auto-reload, without direction enable it reloads on overflow and on a gated trigger fall; with it, down on 0, up on 1.
// (R12) In capture mode timer 2 counts up only and a gated trigger fall copies its count into the reload/capture register.
// (R13) In baud-generator mode timer 2 counts clock/2, never sets its overflow flag, and a trigger fall may still flag.
// (R14) The mode field encodes mode 0 as 00, mode 1 as 01, mode 2 as 10 and mode 3 as 11.
// (R15) Timers 0 and 1 count only while their run bit is set and, when gated, only while their gate pin is high.
`ifndef GTC_CONSTS_VH
`define GTC_CONSTS_VH

// ************************************
// Timing
// ************************************
`define GTC_MCYC_LAST 4'hB
`define GTC_PRESCALE_BITS 5

// ************************************
// Register byte addresses
// ************************************
`define GTC_ADDR_MODECFG 8'h00
`define GTC_ADDR_RUNCTL 8'h04
`define GTC_ADDR_CNT0 8'h08
`define GTC_ADDR_CNT1 8'h0C
`define GTC_ADDR_T2CTL 8'h10
`define GTC_ADDR_T2MODE 8'h14
`define GTC_ADDR_T2CNT 8'h18
`define GTC_ADDR_RELOAD 8'h1C
`define GTC_ADDR_STATUS 8'h20
`define GTC_ADDR_MASK 8'h24

// ************************************
// Field positions
// ************************************
`define GTC_MODE_LO 1:0
`define GTC_CT_LO 2
`define GTC_GATE_LO 3
`define GTC_MODE_HI 5:4
`define GTC_CT_HI 6
`define GTC_GATE_HI 7
`define GTC_T2_CPRL 0
`define GTC_T2_CT 1
`define GTC_T2_RUN 2
`define GTC_T2_TRIGGER_PIN_ENABLE 3
`define GTC_T2_TX_CLOCK_SELECT 4
`define GTC_T2_RX_CLOCK_SELECT 5
`define GTC_ST_TF0 0
`define GTC_ST_TF1 1
`define GTC_ST_TF2 2
`define GTC_ST_EXF2 3

// ************************************
// Encodings and reset values
// ************************************
`define GTC_MODE0 2'b00
`define GTC_MODE1 2'b01
`define GTC_MODE2 2'b10
`define GTC_MODE3 2'b11
`define GTC_RESP_OKAY 2'b00
`define GTC_RESP_SLVERR 2'b10
`define GTC_RST_BYTE 8'h00
`define GTC_RST_WORD 16'h0000

`endif

// [verilog/gtc_pin_sampler.v]
`timescale 1ns/1ps
`include "gtc_consts.vh"

module gtc_pin_sampler #(
  parameter W = 6
) (
  // Clock and reset
  input wire clock,
  input wire reset,
  input wire enable,
  // Machine-cycle sample strobe
  input wire sampleTick,
  // Pins and results
  input wire [W-1:0] pinIn,
  output wire [W-1:0] pinLevel,
  output wire [W-1:0] pinFall
);

  reg [W-1:0] sync1_ff;
  reg [W-1:0] sync2_ff;
  reg [W-1:0] sample_ff;
  reg [W-1:0] fall_ff;

  // Two-stage sync, then one sample per machine cycle
  always @(posedge clock) begin
    if (reset) begin
      sync1_ff <= {W{1'b0}};
      sync2_ff <= {W{1'b0}};
      sample_ff <= {W{1'b0}};
      fall_ff <= {W{1'b0}};
    end else if (enable) begin
      sync1_ff <= pinIn;
      sync2_ff <= sync1_ff;
      if (sampleTick) begin
        sample_ff <= sync2_ff;
        fall_ff <= sample_ff & ~sync2_ff; // R7
      end else begin
        fall_ff <= {W{1'b0}};
      end
    end
  end

  assign pinLevel = sync2_ff;
  assign pinFall = fall_ff;

endmodule

// [verilog/gtc_axil_port.v]
`timescale 1ns/1ps
`include "gtc_consts.vh"

module gtc_axil_port (
  // Clock and reset
  input wire clock,
  input wire reset,
  input wire enable,
  // AXI4-Lite write
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  // AXI4-Lite read
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  // Register file side
  output wire wrEn,
  output wire [7:0] wrAddr,
  output wire [31:0] wrData,
  output wire [3:0] wrStrb,
  input wire wrHit,
  output wire [7:0] rdAddr,
  input wire [31:0] rdData,
  input wire rdHit
);

  reg awHave_ff;
  reg [7:0] awAddr_ff;
  reg wHave_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  reg bValid_ff;
  reg [1:0] bResp_ff;
  reg rValid_ff;
  reg [31:0] rData_ff;
  reg [1:0] rResp_ff;

  // Handshakes; address and data taken in either order
  assign awready = enable & ~awHave_ff & ~bValid_ff;
  assign wready = enable & ~wHave_ff & ~bValid_ff;
  assign arready = enable & ~rValid_ff;
  assign wrEn = enable & awHave_ff & wHave_ff & ~bValid_ff;
  assign wrAddr = awAddr_ff;
  assign wrData = wData_ff;
  assign wrStrb = wStrb_ff;
  assign rdAddr = araddr;

  // Channel state
  always @(posedge clock) begin
    if (reset) begin
      awHave_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wHave_ff <= 1'b0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff <= `GTC_RESP_OKAY;
      rValid_ff <= 1'b0;
      rData_ff <= 32'h00000000;
      rResp_ff <= `GTC_RESP_OKAY;
    end else if (enable) begin
      if (awvalid && awready) begin
        awHave_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_ff <= 1'b1;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end
      if (wrEn) begin
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff <= wrHit ? `GTC_RESP_OKAY : `GTC_RESP_SLVERR;
      end else if (bValid_ff && bready) begin
        bValid_ff <= 1'b0;
      end
      if (arvalid && arready) begin
        rValid_ff <= 1'b1;
        rData_ff <= rdData;
        rResp_ff <= rdHit ? `GTC_RESP_OKAY : `GTC_RESP_SLVERR;
      end else if (rValid_ff && rready) begin
        rValid_ff <= 1'b0;
      end
    end
  end

  assign bvalid = bValid_ff;
  assign bresp = bResp_ff;
  assign rvalid = rValid_ff;
  assign rdata = rData_ff;
  assign rresp = rResp_ff;

endmodule

// [verilog/gtc_timer_set.v]
`timescale 1ns/1ps
`include "gtc_consts.vh"

module gtc_timer_set (
  // Clock, reset, enable
  input wire clock,
  input wire reset,
  input wire clockEnable,
  // AXI4-Lite write
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  // AXI4-Lite read
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  // External pins
  input wire countPinZero,
  input wire countPinOne,
  input wire gatePinZero,
  input wire gatePinOne,
  input wire thirdCountPin,
  input wire triggerPin,
  // Outputs
  output wire irq,
  output wire baudOverflow
);

  // ************************************
  // Helpers
  // ************************************

  // Byte-lane merge of a 16-bit counter word
  function [15:0] gtc_merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      gtc_merge[7:0] = strb[0] ? data[7:0] : old[7:0];
      gtc_merge[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  // One count step of a general timer, returns {overflow, next}
  function [16:0] gtc_step;
    input [15:0] c;
    input [1:0] m;
    input inc;
    reg [5:0] p;
    reg [8:0] h;
    begin
      p = 6'h00;
      h = 9'h000;
      gtc_step = {1'b0, c};
      if (inc) begin
        case (m) // R1 R14
          `GTC_MODE0: begin
            p = {1'b0, c[4:0]} + 6'h01; // R2
            h = {1'b0, c[15:8]} + {8'h00, p[5]};
            gtc_step = {h[8], h[7:0], c[7:5], p[4:0]};
          end
          `GTC_MODE1: begin
            gtc_step = {1'b0, c} + 17'h00001;
          end
          `GTC_MODE2: begin
            if (c[7:0] == 8'hFF) begin
              gtc_step = {1'b1, c[15:8], c[15:8]}; // R3
            end else begin
              gtc_step = {1'b0, c[15:8], c[7:0] + 8'h01};
            end
          end
          default: begin
            gtc_step = {1'b0, c};
          end
        endcase
      end
    end
  endfunction

  // ************************************
  // State
  // ************************************
  reg [3:0] mcDiv_ff;
  reg halfPhase_ff;
  reg [7:0] modeCfg_ff;
  reg [1:0] runCtl_ff;
  reg [15:0] cnt0_ff;
  reg [15:0] cnt1_ff;
  reg [5:0] t2Ctl_ff;
  reg dirEn_ff;
  reg [15:0] cnt2_ff;
  reg [15:0] rcap_ff;
  reg [3:0] stat_ff;
  reg [3:0] mask_ff;
  reg baud_ff;
  reg [15:0] nxt_cnt0;
  reg [15:0] nxt_cnt1;
  reg [15:0] nxt_cnt2;
  reg [15:0] nxt_rcap;
  reg [3:0] setEvt;
  reg [1:0] evt01;
  reg nxt_baud;
  reg [31:0] rdMux;
  reg rdHit;
  reg wrHit;
  reg [16:0] step0;
  reg [16:0] step1;
  reg [8:0] lo0;
  reg [8:0] hi0;

  wire wrEn;
  wire [7:0] wrAddr;
  wire [31:0] wrData;
  wire [3:0] wrStrb;
  wire [7:0] rdAddr;
  wire [5:0] pinLevel;
  wire [5:0] pinFall;

  // ************************************
  // Machine cycle and half-clock ticks
  // ************************************
  wire mcTick = clockEnable & (mcDiv_ff == `GTC_MCYC_LAST); // R5
  wire halfTick = clockEnable & halfPhase_ff;

  gtc_pin_sampler #(
    .W(6)
  ) u_pins (
    .clock(clock),
    .reset(reset),
    .enable(clockEnable),
    .sampleTick(mcTick),
    .pinIn({triggerPin, thirdCountPin, gatePinOne, gatePinZero, countPinOne, countPinZero}),
    .pinLevel(pinLevel),
    .pinFall(pinFall)
  );

  gtc_axil_port u_bus (
    .clock(clock),
    .reset(reset),
    .enable(clockEnable),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrHit(wrHit),
    .rdAddr(rdAddr),
    .rdData(rdMux),
    .rdHit(rdHit)
  );

  // ************************************
  // Count enables
  // ************************************
  wire t0Mode3 = modeCfg_ff[`GTC_MODE_LO] == `GTC_MODE3;
  wire gateOk0 = ~modeCfg_ff[`GTC_GATE_LO] | pinLevel[2]; // R8 R15
  wire gateOk1 = ~modeCfg_ff[`GTC_GATE_HI] | pinLevel[3]; // R8 R15
  wire src0 = modeCfg_ff[`GTC_CT_LO] ? pinFall[0] : mcTick; // R5 R6
  wire src1 = modeCfg_ff[`GTC_CT_HI] ? pinFall[1] : mcTick; // R5 R6
  wire inc0 = clockEnable & runCtl_ff[0] & gateOk0 & src0; // R15
  wire inc1 = clockEnable & runCtl_ff[1] & gateOk1 & src1 & (modeCfg_ff[`GTC_MODE_HI] != `GTC_MODE3); // R4 R15
  wire t0HiInc = runCtl_ff[1] & mcTick;
  wire brg = t2Ctl_ff[`GTC_T2_RX_CLOCK_SELECT] | t2Ctl_ff[`GTC_T2_TX_CLOCK_SELECT];
  wire inc2 = clockEnable & t2Ctl_ff[`GTC_T2_RUN] &
              (t2Ctl_ff[`GTC_T2_CT] ? pinFall[4] : (brg ? halfTick : mcTick)); // R9 R10 R13
  wire trig2 = clockEnable & t2Ctl_ff[`GTC_T2_TRIGGER_PIN_ENABLE] & pinFall[5];
  wire cntMax2 = cnt2_ff == 16'hFFFF;

  // ************************************
  // Timers 0 and 1 next state
  // ************************************
  always @* begin
    step0 = gtc_step(cnt0_ff, modeCfg_ff[`GTC_MODE_LO], inc0);
    step1 = gtc_step(cnt1_ff, modeCfg_ff[`GTC_MODE_HI], inc1);
    lo0 = {1'b0, cnt0_ff[7:0]} + {8'h00, inc0};
    hi0 = {1'b0, cnt0_ff[15:8]} + {8'h00, t0HiInc};
    evt01 = 2'b00;
    if (t0Mode3) begin
      nxt_cnt0 = {hi0[7:0], lo0[7:0]}; // R4
      evt01[`GTC_ST_TF0] = lo0[8];
      evt01[`GTC_ST_TF1] = hi0[8]; // R4
    end else begin
      nxt_cnt0 = step0[15:0];
      evt01[`GTC_ST_TF0] = step0[16];
      evt01[`GTC_ST_TF1] = step1[16];
    end
    nxt_cnt1 = step1[15:0];
    if (wrEn && wrAddr == `GTC_ADDR_CNT0) nxt_cnt0 = gtc_merge(cnt0_ff, wrData, wrStrb);
    if (wrEn && wrAddr == `GTC_ADDR_CNT1) nxt_cnt1 = gtc_merge(cnt1_ff, wrData, wrStrb);
  end

  // ************************************
  // Timer 2 next state
  // ************************************
  always @* begin
    nxt_cnt2 = cnt2_ff;
    nxt_rcap = rcap_ff;
    nxt_baud = 1'b0;
    setEvt = {2'b00, evt01}; // Timer 0/1 flags, one driver
    if (brg) begin
      if (inc2) begin
        nxt_cnt2 = cntMax2 ? rcap_ff : cnt2_ff + 16'h0001; // R13
        nxt_baud = cntMax2;
      end
      setEvt[`GTC_ST_EXF2] = trig2; // R13
    end else if (t2Ctl_ff[`GTC_T2_CPRL]) begin
      if (inc2) begin
        nxt_cnt2 = cnt2_ff + 16'h0001; // R12
        setEvt[`GTC_ST_TF2] = cntMax2;
      end
      if (trig2) begin
        nxt_rcap = cnt2_ff; // R12
        setEvt[`GTC_ST_EXF2] = 1'b1;
      end
    end else if (dirEn_ff) begin
      if (inc2 && pinLevel[5]) begin
        nxt_cnt2 = cntMax2 ? rcap_ff : cnt2_ff + 16'h0001; // R11
        setEvt[`GTC_ST_TF2] = cntMax2;
      end else if (inc2) begin
        nxt_cnt2 = (cnt2_ff == rcap_ff) ? 16'hFFFF : cnt2_ff - 16'h0001; // R11
        setEvt[`GTC_ST_TF2] = cnt2_ff == rcap_ff;
      end
    end else begin
      if (inc2) begin
        nxt_cnt2 = cntMax2 ? rcap_ff : cnt2_ff + 16'h0001; // R11
        setEvt[`GTC_ST_TF2] = cntMax2;
      end
      if (trig2) begin
        nxt_cnt2 = rcap_ff; // R11
        setEvt[`GTC_ST_EXF2] = 1'b1;
      end
    end
    if (wrEn && wrAddr == `GTC_ADDR_T2CNT) nxt_cnt2 = gtc_merge(cnt2_ff, wrData, wrStrb);
    if (wrEn && wrAddr == `GTC_ADDR_RELOAD) nxt_rcap = gtc_merge(rcap_ff, wrData, wrStrb);
  end

  // ************************************
  // Register read and decode
  // ************************************
  always @* begin
    rdHit = 1'b1;
    case (rdAddr)
      `GTC_ADDR_MODECFG: rdMux = {24'h000000, modeCfg_ff};
      `GTC_ADDR_RUNCTL: rdMux = {30'h0, runCtl_ff};
      `GTC_ADDR_CNT0: rdMux = {16'h0000, cnt0_ff};
      `GTC_ADDR_CNT1: rdMux = {16'h0000, cnt1_ff};
      `GTC_ADDR_T2CTL: rdMux = {26'h0, t2Ctl_ff};
      `GTC_ADDR_T2MODE: rdMux = {31'h0, dirEn_ff};
      `GTC_ADDR_T2CNT: rdMux = {16'h0000, cnt2_ff};
      `GTC_ADDR_RELOAD: rdMux = {16'h0000, rcap_ff};
      `GTC_ADDR_STATUS: rdMux = {28'h0000000, stat_ff};
      `GTC_ADDR_MASK: rdMux = {28'h0000000, mask_ff};
      default: begin
        rdMux = 32'h00000000;
        rdHit = 1'b0;
      end
    endcase
    case (wrAddr)
      `GTC_ADDR_MODECFG, `GTC_ADDR_RUNCTL, `GTC_ADDR_CNT0, `GTC_ADDR_CNT1, `GTC_ADDR_T2CTL,
      `GTC_ADDR_T2MODE, `GTC_ADDR_T2CNT, `GTC_ADDR_RELOAD, `GTC_ADDR_STATUS, `GTC_ADDR_MASK: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // ************************************
  // Registers
  // ************************************
  wire wrLow = wrEn & wrStrb[0];
  wire [3:0] clrStat = (wrLow && wrAddr == `GTC_ADDR_STATUS) ? wrData[3:0] : 4'h0;

  always @(posedge clock) begin
    if (reset) begin
      mcDiv_ff <= 4'h0;
      halfPhase_ff <= 1'b0;
      modeCfg_ff <= `GTC_RST_BYTE;
      runCtl_ff <= 2'b00;
      cnt0_ff <= `GTC_RST_WORD;
      cnt1_ff <= `GTC_RST_WORD;
      t2Ctl_ff <= 6'h00;
      dirEn_ff <= 1'b0;
      cnt2_ff <= `GTC_RST_WORD;
      rcap_ff <= `GTC_RST_WORD;
      stat_ff <= 4'h0;
      mask_ff <= 4'h0;
      baud_ff <= 1'b0;
    end else if (clockEnable) begin
      mcDiv_ff <= mcTick ? 4'h0 : mcDiv_ff + 4'h1; // R5
      halfPhase_ff <= ~halfPhase_ff; // R13
      cnt0_ff <= nxt_cnt0;
      cnt1_ff <= nxt_cnt1;
      cnt2_ff <= nxt_cnt2;
      rcap_ff <= nxt_rcap;
      baud_ff <= nxt_baud;
      stat_ff <= (stat_ff & ~clrStat) | setEvt; // Set wins over clear
      if (wrLow && wrAddr == `GTC_ADDR_MODECFG) modeCfg_ff <= wrData[7:0]; // R1
      if (wrLow && wrAddr == `GTC_ADDR_RUNCTL) runCtl_ff <= wrData[1:0];
      if (wrLow && wrAddr == `GTC_ADDR_T2CTL) t2Ctl_ff <= wrData[5:0]; // R10
      if (wrLow && wrAddr == `GTC_ADDR_T2MODE) dirEn_ff <= wrData[0];
      if (wrLow && wrAddr == `GTC_ADDR_MASK) mask_ff <= wrData[3:0];
    end
  end

  // Interrupt level and baud pulse
  assign irq = |(stat_ff & mask_ff);
  assign baudOverflow = baud_ff;

endmodule

// [verif/gtc_timer_set_props.sv]
`timescale 1ns/1ps
// ****
// Bus handshake and baud pulse checks
// ****
module gtc_timer_set_props (
  // Clock and reset
  input wire clock,
  input wire reset,
  input wire clockEnable,
  // Write side
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  // Read side
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready,
  // Outputs
  input wire baudOverflow
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Handshake steps
  sequence wrTaken; awvalid && awready && wvalid && wready; endsequence
  sequence rdTaken; arvalid && arready && clockEnable; endsequence
  sequence rdDone; rvalid && rready && clockEnable; endsequence
  // Answers and holding
  chk_write_answer: assert property (wrTaken |-> ##[1:4] bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (rdTaken |=> rvalid)
    else $error("read data late");
  chk_bresp_stable: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_rdata_stable: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  chk_rvalid_drop: assert property (rdDone |=> !rvalid)
    else $error("read data held after accept");
  // Refusals and baud pulse length
  chk_read_refused: assert property (rvalid |-> !arready)
    else $error("read accepted while busy");
  chk_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while busy");
  chk_freeze_readies: assert property (!clockEnable |-> !awready && !wready && !arready)
    else $error("ready while frozen");
  chk_baud_pulse: assert property (baudOverflow |=> !baudOverflow)
    else $error("baud pulse too long");
endmodule

bind gtc_timer_set gtc_timer_set_props chk (.clock(clock), .reset(reset), .clockEnable(clockEnable),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .baudOverflow(baudOverflow));

// [verif/gtc_pin_model.sv]
`timescale 1ns/1ps
// ****
// External pin driver
// ****
module gtc_pin_model (
  // Clock
  input wire clock,
  // Pins
  output wire countPinZero,
  output wire countPinOne,
  output wire thirdCountPin,
  output wire triggerPin,
  output wire gatePinZero,
  output wire gatePinOne
);
  reg [5:0] pinsOut = 6'h3F;
  // Pin order by select code
  assign {gatePinOne, gatePinZero, triggerPin, thirdCountPin, countPinOne, countPinZero} = pinsOut;
  // Falling edges, each level held 14 clocks
  task pulse(input integer sel, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clock);
        pinsOut[sel] <= 1'b0;
        repeat (14) @(posedge clock);
        pinsOut[sel] <= 1'b1;
        repeat (13) @(posedge clock);
      end
    end
  endtask
  // Static level change
  task level(input integer sel, input v);
    begin
      @(posedge clock);
      pinsOut[sel] <= v;
      repeat (14) @(posedge clock);
    end
  endtask
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
`include "gtc_consts.vh"
module tb;
  localparam [7:0] MC = `GTC_ADDR_MODECFG, RN = `GTC_ADDR_RUNCTL, C0 = `GTC_ADDR_CNT0, C1 = `GTC_ADDR_CNT1;
  localparam [7:0] T2C = `GTC_ADDR_T2CTL, T2M = `GTC_ADDR_T2MODE, T2N = `GTC_ADDR_T2CNT, RL = `GTC_ADDR_RELOAD;
  localparam [7:0] ST = `GTC_ADDR_STATUS, MK = `GTC_ADDR_MASK;
  reg clock, reset, clockEnable, awvalid, wvalid, bready, arvalid, rready;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, got;
  reg [3:0] wstrb;
  reg [1:0] resp;
  wire awready, wready, bvalid, arready, rvalid, irq, baudOverflow;
  wire countPinZero, countPinOne, thirdCountPin, triggerPin, gatePinZero, gatePinOne;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer miscompares, comparisons, b;
  // ****
  // Design and pin partner
  // ****
  gtc_timer_set dut (.clock(clock), .reset(reset), .clockEnable(clockEnable), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .countPinZero(countPinZero),
    .countPinOne(countPinOne), .gatePinZero(gatePinZero), .gatePinOne(gatePinOne),
    .thirdCountPin(thirdCountPin), .triggerPin(triggerPin), .irq(irq), .baudOverflow(baudOverflow));
  gtc_pin_model pins (.clock(clock), .countPinZero(countPinZero), .countPinOne(countPinOne),
    .thirdCountPin(thirdCountPin), .triggerPin(triggerPin), .gatePinZero(gatePinZero), .gatePinOne(gatePinOne));
  // Clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ****
  // Report and compare
  // ****
  task results;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] a);
    begin
      comparisons = comparisons + 1;
      if (a !== e) begin
        miscompares = miscompares + 1;
        $display("BAD %s expected %h seen %h", nm, e, a);
      end
    end
  endtask
  task chkIn(input string nm, input [31:0] lo, input [31:0] hi, input [31:0] a);
    begin
      comparisons = comparisons + 1;
      if (^a === 1'bx || a < lo || a > hi) begin
        miscompares = miscompares + 1;
        $display("BAD %s expected %h to %h seen %h", nm, lo, hi, a);
      end
    end
  endtask
  task tout;
    begin
      miscompares = miscompares + 1;
      $display("BAD bus wait expected answer seen none");
      results;
    end
  endtask
  // ****
  // Bus master, entered just after a rising edge
  // ****
  task wr(input [7:0] a, input [31:0] d);
    integer n;
    reg ah, wh, bh, vb;
    begin
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
      n = 0;
      bh = 1'b0;
      while (!bh && n < 50) begin
        @(negedge clock);
        ah = awready; wh = wready; vb = bvalid; bh = vb && bready; resp = bresp;
        @(posedge clock);
        if (ah) awvalid <= 1'b0;
        if (wh) wvalid <= 1'b0;
        if (vb && !bh) bready <= 1'b1;
        n = n + 1;
      end
      bready <= 1'b0;
      if (!bh) tout;
    end
  endtask
  task rd(input [7:0] a);
    integer n;
    reg ah, rh, vr;
    begin
      araddr <= a; arvalid <= 1'b1;
      n = 0;
      rh = 1'b0;
      while (!rh && n < 50) begin
        @(negedge clock);
        ah = arready; vr = rvalid; rh = vr && rready; got = rdata; resp = rresp;
        @(posedge clock);
        if (ah) arvalid <= 1'b0;
        if (vr && !rh) rready <= 1'b1;
        n = n + 1;
      end
      rready <= 1'b0;
      if (!rh) tout;
    end
  endtask
  task rc(input string nm, input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(nm, e, got);
    end
  endtask
  task irqChk(input e);
    begin
      @(negedge clock);
      chk("irq", {31'h0, e}, {31'h0, irq});
      @(posedge clock);
    end
  endtask
  task timed(input [7:0] a, input [31:0] on, input integer n);
    begin
      wr(a, on); repeat (n) @(posedge clock); wr(a, 32'h0); rd(a == RN ? C0 : T2N);
    end
  endtask
  // ****
  // Test sequence
  // ****
  initial begin
    reset = 1'b1; clockEnable = 1'b1; awaddr = 8'h0; araddr = 8'h0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; wdata = 32'h0; wstrb = 4'hF; miscompares = 0; comparisons = 0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rc("modecfg", MC, 32'h0); rc("count0", C0, 32'h0); rc("t2ctl", T2C, 32'h0); rc("status", ST, 32'h0);
    rd(8'h40); chk("rdresp", 32'h2, {30'h0, resp}); chk("rddata", 32'h0, got);
    wr(8'h40, 32'hFF); chk("wrresp", 32'h2, {30'h0, resp});
    clockEnable <= 1'b0; @(negedge clock); chk("frozen", 32'h0, {31'h0, arready}); @(posedge clock);
    clockEnable <= 1'b1; $display("test reset done");
    wr(C0, 32'h0); wr(MC, 32'h1); timed(RN, 32'h1, 120); chkIn("mode1", 32'h9, 32'hC, got);
    wr(C0, 32'h0); wr(MC, 32'h0); timed(RN, 32'h1, 480); chk("mode0", 32'h1, {24'h0, got[15:8]});
    wr(ST, 32'hF); wr(C0, 32'hF0FC); wr(MC, 32'h2); timed(RN, 32'h1, 120);
    chkIn("mode2", 32'hF0F5, 32'hF0F7, got); rc("tf0", ST, 32'h1);
    irqChk(1'b0); wr(MK, 32'h1); irqChk(1'b1); wr(ST, 32'h1); irqChk(1'b0); rc("w1c", ST, 32'h0);
    wr(C0, 32'h0); wr(MC, 32'h3); timed(RN, 32'h2, 60); chkIn("split", 32'h400, 32'h600, got);
    wr(C1, 32'h0); wr(MC, 32'h31); wr(RN, 32'h3); repeat (60) @(posedge clock); rc("t1halt", C1, 32'h0);
    $display("test modes done");
    wr(C0, 32'h0); wr(C1, 32'h0); wr(MC, 32'h55); wr(RN, 32'h3); pins.pulse(0, 5); pins.pulse(1, 2);
    wr(RN, 32'h0); rc("events0", C0, 32'h5); rc("events1", C1, 32'h2);
    wr(C0, 32'h0); wr(MC, 32'h0D); wr(RN, 32'h1); pins.level(4, 1'b0); pins.pulse(0, 3);
    rc("gated", C0, 32'h0); pins.level(4, 1'b1); pins.pulse(0, 3); rc("open", C0, 32'h3);
    wr(RN, 32'h0); pins.pulse(0, 2); rc("stopped", C0, 32'h3);
    $display("test counters done");
    wr(ST, 32'hF); wr(RL, 32'h0); wr(T2N, 32'h1234); wr(T2C, 32'h09); pins.pulse(3, 1);
    rc("capture", RL, 32'h1234); rc("t2stop", T2N, 32'h1234); rc("exf2", ST, 32'h8);
    wr(RL, 32'hABCD); wr(T2C, 32'h08); wr(T2N, 32'h1); pins.pulse(3, 1); rc("trigload", T2N, 32'hABCD);
    wr(ST, 32'hF); wr(T2N, 32'hFFFE); timed(T2C, 32'h4, 30);
    chkIn("ovfload", 32'hABCD, 32'hABCF, got); rc("tf2", ST, 32'h4);
    wr(T2M, 32'h1); wr(RL, 32'h0); pins.level(3, 1'b0); wr(T2N, 32'h10); timed(T2C, 32'h4, 60);
    chkIn("down", 32'hA, 32'hC, got);
    pins.level(3, 1'b1); wr(T2N, 32'h10); timed(T2C, 32'h4, 60); chkIn("up", 32'h14, 32'h16, got);
    wr(T2M, 32'h0); wr(T2N, 32'h0); wr(T2C, 32'h06); pins.pulse(2, 4); wr(T2C, 32'h0);
    rc("t2events", T2N, 32'h4);
    wr(ST, 32'hF); wr(RL, 32'hFFF0); wr(T2N, 32'hFFF0); wr(T2C, 32'h14);
    b = 0;
    repeat (320) begin
      @(negedge clock);
      if (baudOverflow === 1'b1) b = b + 1;
    end
    @(posedge clock);
    wr(T2C, 32'h0); chkIn("baud", 32'h9, 32'hB, b); rc("notf2", ST, 32'h0);
    wr(ST, 32'hF); wr(T2C, 32'h28); pins.pulse(3, 1); rc("brgexf", ST, 32'h8);
    $display("test timer2 done");
    results;
  end
endmodule
